// ==== boot_pkg.sv ====
/*
  Shared constants and types for the serial boot entry block.
  Assumes a 250 MHz ref_clk where one processor state is one clock.
*/
`default_nettype none
package boot_pkg;
  // ****************************************
  // Memory windows
  // ****************************************
  localparam logic [23:0] LOAD_LO = 24'hfff400;
  localparam logic [23:0] LOAD_HI = 24'hfffbff;
  localparam logic [23:0] RSV_LO  = 24'hffec00;
  localparam logic [23:0] RSV_HI  = 24'hfff3ff;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PER_STATE   = 1;
  localparam int SETTLE_STATES   = 100;
  localparam int SETTLE_CYC      = SETTLE_STATES * CLK_PER_STATE;
  localparam int INIT_MIN_STATES = 20;
  localparam int INIT_MIN_CYC    = INIT_MIN_STATES * CLK_PER_STATE;
  localparam int LOW_BITS        = 9;
  // ****************************************
  // Bytes and modes
  // ****************************************
  localparam logic [7:0] ACK_BYTE  = 8'h00;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [3:0] MODE_BOOT_EXP = 4'ha;
  localparam logic [3:0] MODE_BOOT_SC  = 4'hb;
  localparam logic [3:0] MODE_UPG_EXP  = 4'he;
  localparam logic [3:0] MODE_UPG_SC   = 4'hf;
  localparam logic [3:0] MODE_USER_EXP = 4'h6;
  localparam logic [3:0] MODE_USER_SC  = 4'h7;
  localparam logic [3:0] MODE_RST      = 4'h0;
  // ****************************************
  // Registers
  // ****************************************
  localparam logic [3:0]  OFS_CTRL = 4'h0;
  localparam logic [3:0]  OFS_STAT = 4'h4;
  localparam logic [3:0]  OFS_DIV  = 4'h8;
  localparam logic [3:0]  OFS_CNT  = 4'hc;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  localparam logic [1:0]  RESP_OK  = 2'b00;
  localparam logic [1:0]  RESP_ERR = 2'b10;
  typedef enum logic [3:0] {
    S_INIT, S_SETTLE, S_WLOW, S_MEAS, S_ACK, S_SYNC, S_BLANK,
    S_ERASE, S_LEN0, S_LEN1, S_LOAD, S_BRANCH, S_RUN, S_USER
  } boot_st_t;
endpackage
`default_nettype wire

// ==== link_if.sv ====
/*
  Carrier between the boot sequencer and its character engine.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  logic [15:0] divisor;
  logic        txEn;
  logic        rxEn;
  logic        txStart;
  logic [7:0]  txData;
  logic        txBusy;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxLine;
  logic        txLine;
  modport ctl  (output divisor, txEn, rxEn, txStart, txData, rxLine,
                input txBusy, rxValid, rxData, txLine);
  modport uart (input divisor, txEn, rxEn, txStart, txData, rxLine,
                output txBusy, rxValid, rxData, txLine);
endinterface
`default_nettype wire

// ==== boot_uart.sv ====
/*
  Asynchronous character engine: 8 data bits, 1 stop bit, no parity.
  Assumes rxLine is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module boot_uart
  import boot_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Link side
  link_if.uart      lnk
);
  logic [15:0] txCnt_r;
  logic [3:0]  txBit_r;
  logic [9:0]  txSh_r;
  logic [15:0] rxCnt_r;
  logic [3:0]  rxBit_r;
  logic [7:0]  rxSh_r;
  logic        rxBusy_r;
  logic        rxPrev_r;
  wire         txTick = (txCnt_r == lnk.divisor - 16'd1);
  wire         rxTick = (rxCnt_r == 16'd0);
  wire         rxFall = rxPrev_r & ~lnk.rxLine;

  // ****************************************
  // Transmitter
  // ****************************************
  // R4 - character framing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      txCnt_r     <= 16'd0;
      txBit_r     <= 4'd0;
      txSh_r      <= 10'h3ff;
      lnk.txBusy  <= 1'b0;
      lnk.txLine  <= 1'b1;
    end else if (!lnk.txEn) begin
      lnk.txBusy  <= 1'b0;
      lnk.txLine  <= 1'b1;
      txBit_r     <= 4'd0;
    end else if (lnk.txStart && !lnk.txBusy) begin
      txSh_r      <= {1'b1, lnk.txData, 1'b0};
      txCnt_r     <= 16'd0;
      txBit_r     <= 4'd0;
      lnk.txBusy  <= 1'b1;
    end else if (lnk.txBusy) begin
      lnk.txLine  <= txSh_r[txBit_r];
      txCnt_r     <= txTick ? 16'd0 : txCnt_r + 16'd1;
      if (txTick) begin
        txBit_r   <= txBit_r + 4'd1;
        if (txBit_r == 4'd9) begin
          lnk.txBusy <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxCnt_r     <= 16'd0;
      rxBit_r     <= 4'd0;
      rxSh_r      <= 8'h00;
      rxBusy_r    <= 1'b0;
      rxPrev_r    <= 1'b1;
      lnk.rxValid <= 1'b0;
      lnk.rxData  <= 8'h00;
    end else begin
      rxPrev_r    <= lnk.rxLine;
      lnk.rxValid <= 1'b0;
      if (!lnk.rxEn) begin
        rxBusy_r  <= 1'b0;
      end else if (!rxBusy_r && rxFall) begin
        rxBusy_r  <= 1'b1;
        rxBit_r   <= 4'd0;
        rxCnt_r   <= lnk.divisor >> 1;
      end else if (rxBusy_r) begin
        rxCnt_r   <= rxTick ? lnk.divisor - 16'd1 : rxCnt_r - 16'd1;
        if (rxTick) begin
          rxBit_r <= rxBit_r + 4'd1;
          if (rxBit_r >= 4'd1 && rxBit_r <= 4'd8) begin
            rxSh_r <= {lnk.rxLine, rxSh_r[7:1]};
          end
          if (rxBit_r == 4'd9) begin
            rxBusy_r    <= 1'b0;
            lnk.rxValid <= lnk.rxLine;
            lnk.rxData  <= rxSh_r;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== boot_loader_entry.sv ====
/*
  Flash programming mode selection and serial boot loader sequencer.
  Assumes an AXI4-Lite master on ref_clk and pins from outside the domain.
*/
// Functional notes
// R1 - Write enable high and mode 0,1,x at init release selects boot mode 10/11.
// R2 - Write enable high and mode 1,1,x selects user program mode 14/15.
// R3 - Boot loads host program into FFF400..FFFBFF then branches to its start.
// R4 - Link framing is eight data bits, one stop bit, no parity.
// R5 - Device times low period of repeated zero bytes to find host bit rate.
// R6 - After adjustment device sends exactly one zero byte as completion.
// R7 - Host checks the zero byte then sends one 55 byte, else resets; host_model sends nothing instead of resetting.
// R8 - Host transmits at 9600 or 4800 bps within supported clock ranges; host_model uses 80 ns bits instead.
// R9 - Region FFEC00..FFF3FF stays reserved for the loader until program runs.
// R10 - Host keeps receive line high when init is released in boot mode.
// R11 - Low period timing begins about 100 states after init ends.
// R12 - If flash is not blank, every block is erased before program runs.
// R13 - Interrupts are blocked while flash programs or erases.
// R14 - Before branching, serial rx and tx stop, divisor kept, tx pin high.
// R15 - Downloaded program sets its stack and registers after the branch.
// R16 - Leaving boot mode needs the init pin low at least 20 states.
// R17 - Mode and write enable pins stay fixed during boot mode.
// R18 - Pin changes during init switch bus strobes and address ports.
// R19 - User program mode blocks flash reads while the unlock bit is set.
// R20 - In user program mode peripherals behave as in user modes 6 and 7.
// R21 - Host normally uses modes 6 and 7, raising write enable to program.
// R22 - Clock count of nine low bits divided by nine gives the divisor.
`timescale 1ns/1ps
`default_nettype none
module boot_loader_entry
  import boot_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Mode pins
  input  wire logic        flashWriteEnablePin,
  input  wire logic        modeSelectBit2,
  input  wire logic        modeSelectBit1,
  input  wire logic        modeSelectBit0,
  input  wire logic        hardwareInitPin_b,
  // Serial pins
  input  wire logic        bootSerialRxPin,
  output logic             bootSerialTxPin,
  output logic             bootSerialTxPinOe,
  // Flash and core
  input  wire logic        flashBlank,
  input  wire logic        eraseDone,
  input  wire logic        flashBusy,
  output logic             eraseAllReq,
  output logic             irqBlock,
  output logic             flashReadBlock,
  output logic             loaderReserved,
  output logic             branchReq,
  output logic [23:0]      branchAddr,
  output logic [3:0]       opMode,
  output logic [3:0]       periphMode,
  output logic             expandedBus,
  // Program RAM write port
  output logic             ramWrEn,
  output logic [23:0]      ramWrAddr,
  output logic [7:0]       ramWrData,
  // AXI4-Lite slave
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  function automatic logic [3:0] decodeMode(input logic flash_write_enable_pin, input logic [2:0] md);
    logic [3:0] m;
    m = MODE_RST;
    if (md[2:1] == 2'b01 && flash_write_enable_pin) m = md[0] ? MODE_BOOT_SC : MODE_BOOT_EXP;
    else if (md[2:1] == 2'b11) m = flash_write_enable_pin ? (md[0] ? MODE_UPG_SC : MODE_UPG_EXP)
                                       : (md[0] ? MODE_USER_SC : MODE_USER_EXP);
    else m = {1'b0, md};
    return m;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] pinS1_r;
  logic [5:0] pinS2_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1_r <= 6'h22;
      pinS2_r <= 6'h22;
    end else begin
      pinS1_r <= {bootSerialRxPin, hardwareInitPin_b, flashWriteEnablePin,
                  modeSelectBit2, modeSelectBit1, modeSelectBit0};
      pinS2_r <= pinS1_r;
    end
  end
  wire       rxS    = pinS2_r[5];
  wire       initS  = pinS2_r[4];
  wire [3:0] pinMode = decodeMode(pinS2_r[3], pinS2_r[2:0]);
  wire       isBoot = (pinMode == MODE_BOOT_EXP) || (pinMode == MODE_BOOT_SC);

  link_if lnk ();
  boot_uart u_uart (.ref_clk(ref_clk), .rst_b(rst_b), .lnk(lnk));

  // ****************************************
  // Mode capture
  // ****************************************
  boot_st_t    st_r;
  boot_st_t    st_nxt;
  logic        initPrev_r;
  logic [4:0]  initCnt_r;
  logic        bootMode_r;
  logic        swe_r;
  logic        flashClean_r;
  logic        branched_r;
  wire         initRise = initS & ~initPrev_r;
  wire         initLong = (initCnt_r >= 5'(INIT_MIN_CYC));
  wire         userProg = (opMode == MODE_UPG_EXP) || (opMode == MODE_UPG_SC);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      initPrev_r <= 1'b0;
      initCnt_r  <= 5'd0;
      opMode     <= MODE_RST;
      bootMode_r <= 1'b0;
    end else begin
      initPrev_r <= initS;
      if (!initS && !initLong) initCnt_r <= initCnt_r + 5'd1;
      if (initS) initCnt_r <= 5'd0;
      // R18 R16 - follow pins during init
      if (!initS && (initLong || !bootMode_r)) opMode <= pinMode;
      // R1 R2 R16 - latch mode at release
      if (initRise && (initLong || !bootMode_r)) bootMode_r <= isBoot;
    end
  end
  // R20 R19 R13 R9 - mode derived outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      expandedBus    <= 1'b0;
      periphMode     <= MODE_RST;
      flashReadBlock <= 1'b0;
      irqBlock       <= 1'b0;
      loaderReserved <= 1'b0;
    end else begin
      expandedBus    <= ~opMode[0];
      periphMode     <= userProg ? {2'b01, 1'b1, opMode[0]} : opMode;
      flashReadBlock <= userProg & swe_r;
      irqBlock       <= flashBusy | eraseAllReq;
      loaderReserved <= bootMode_r & ~branched_r;
    end
  end

  // ****************************************
  // Boot sequencer
  // ****************************************
  logic [6:0]  settleCnt_r;
  logic [3:0]  pre_r;
  logic [15:0] bitCnt_r;
  logic [15:0] div_r;
  logic [15:0] len_r;
  logic [15:0] cnt_r;
  logic        txStart_r;
  logic        rxEn_r;
  logic        txEn_r;
  wire         rxByte = lnk.rxValid;
  wire         lenLast = (cnt_r + 16'd1 >= len_r);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_INIT:   if (initRise && isBoot && (initLong || !bootMode_r)) st_nxt = S_SETTLE;
      S_SETTLE: if (settleCnt_r == 7'(SETTLE_CYC - 1)) st_nxt = S_WLOW;
      S_WLOW:   if (!rxS) st_nxt = S_MEAS;
      S_MEAS:   if (rxS) st_nxt = S_ACK;
      S_ACK:    if (!txStart_r && !lnk.txBusy) st_nxt = S_SYNC;
      S_SYNC:   if (rxByte && lnk.rxData == SYNC_BYTE) st_nxt = S_BLANK;
                else if (rxByte && lnk.rxData != ACK_BYTE) st_nxt = S_WLOW;
      S_BLANK:  st_nxt = flashBlank ? S_LEN0 : S_ERASE;
      S_ERASE:  if (eraseDone) st_nxt = S_LEN0;
      S_LEN0:   if (rxByte) st_nxt = S_LEN1;
      S_LEN1:   if (rxByte) st_nxt = S_LOAD;
      S_LOAD:   if (rxByte && lenLast) st_nxt = S_BRANCH;
      S_BRANCH: st_nxt = S_RUN;
      S_RUN:    st_nxt = S_RUN;
      S_USER:   st_nxt = S_USER;
      default:  st_nxt = S_INIT;
    endcase
    if (!initS) st_nxt = S_INIT;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) st_r <= S_INIT;
    else st_r <= st_nxt;
  end

  // R11 - settle before timing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) settleCnt_r <= 7'd0;
    else settleCnt_r <= (st_r == S_SETTLE) ? settleCnt_r + 7'd1 : 7'd0;
  end

  // R5 R22 - low period over nine bits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r    <= 4'd0;
      bitCnt_r <= 16'd0;
      div_r    <= DIV_RST;
    end else if (st_r == S_WLOW) begin
      pre_r    <= rxS ? 4'd0 : 4'd1;
      bitCnt_r <= 16'd0;
    end else if (st_r == S_MEAS && !rxS) begin
      pre_r    <= (pre_r == 4'(LOW_BITS - 1)) ? 4'd0 : pre_r + 4'd1;
      if (pre_r == 4'(LOW_BITS - 1) && bitCnt_r != 16'hffff) begin
        bitCnt_r <= bitCnt_r + 16'd1;
      end
    end else if (st_r == S_MEAS) begin
      div_r    <= (bitCnt_r == 16'd0) ? DIV_RST : bitCnt_r;
    end
  end

  // R6 R14 R3 R12 - link, load and branch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      txStart_r    <= 1'b0;
      rxEn_r       <= 1'b0;
      txEn_r       <= 1'b0;
      len_r        <= 16'd0;
      cnt_r        <= 16'd0;
      eraseAllReq  <= 1'b0;
      flashClean_r <= 1'b0;
      branched_r   <= 1'b0;
      branchReq    <= 1'b0;
      branchAddr   <= LOAD_LO;
      ramWrEn      <= 1'b0;
      ramWrAddr    <= LOAD_LO;
      ramWrData    <= 8'h00;
    end else begin
      txStart_r <= (st_r == S_MEAS) && rxS;
      ramWrEn   <= 1'b0;
      branchReq <= 1'b0;
      if (st_r == S_MEAS && rxS) begin
        txEn_r <= 1'b1;
        rxEn_r <= 1'b1;
      end
      if (st_r == S_INIT) begin
        branched_r   <= 1'b0;
        flashClean_r <= 1'b0;
        txEn_r       <= 1'b0;
        rxEn_r       <= 1'b0;
      end
      if (st_r == S_BLANK) begin
        flashClean_r <= flashBlank;
        eraseAllReq  <= ~flashBlank;
      end
      if (st_r == S_ERASE && eraseDone) begin
        eraseAllReq  <= 1'b0;
        flashClean_r <= 1'b1;
      end
      if (st_r == S_LEN0 && rxByte) len_r[15:8] <= lnk.rxData;
      if (st_r == S_LEN1 && rxByte) begin
        len_r[7:0] <= lnk.rxData;
        cnt_r      <= 16'd0;
      end
      if (st_r == S_LOAD && rxByte) begin
        ramWrEn   <= (cnt_r <= 16'(LOAD_HI - LOAD_LO));
        ramWrAddr <= LOAD_LO + 24'(cnt_r);
        ramWrData <= lnk.rxData;
        cnt_r     <= cnt_r + 16'd1;
      end
      if (st_r == S_BRANCH) begin
        txEn_r     <= 1'b0;
        rxEn_r     <= 1'b0;
        branchReq  <= 1'b1;
        branchAddr <= LOAD_LO;
        branched_r <= 1'b1;
      end
    end
  end

  assign lnk.divisor = div_r;
  assign lnk.txEn    = txEn_r;
  assign lnk.rxEn    = rxEn_r;
  assign lnk.txStart = txStart_r;
  assign lnk.txData  = ACK_BYTE;
  assign lnk.rxLine  = rxS;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bootSerialTxPin   <= 1'b1;
      bootSerialTxPinOe <= 1'b0;
    end else begin
      bootSerialTxPin   <= lnk.txLine;
      bootSerialTxPinOe <= bootMode_r;
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic       awHeld_r;
  logic       wHeld_r;
  logic [3:0] awA_r;
  logic [31:0] wD_r;
  logic [3:0] wS_r;
  wire        wrGo   = awHeld_r & wHeld_r & ~bvalid;
  wire        wrCtrl = (awA_r == OFS_CTRL);
  wire        wrOk   = wrCtrl || awA_r == OFS_STAT || awA_r == OFS_DIV || awA_r == OFS_CNT;
  wire [31:0] rdMux  = (araddr == OFS_CTRL) ? {31'd0, swe_r} :
                       (araddr == OFS_STAT) ? {16'd0, 4'(st_r), opMode, 4'd0,
                                               flashClean_r, branched_r, userProg, bootMode_r} :
                       (araddr == OFS_DIV)  ? {16'd0, div_r} :
                       (araddr == OFS_CNT)  ? {16'd0, cnt_r} : 32'd0;
  wire        rdOk   = (araddr == OFS_CTRL) || (araddr == OFS_STAT) ||
                       (araddr == OFS_DIV) || (araddr == OFS_CNT);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awA_r    <= 4'd0;
      wD_r     <= 32'd0;
      wS_r     <= 4'd0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OK;
      arready  <= 1'b0;
      rvalid   <= 1'b0;
      rresp    <= RESP_OK;
      rdata    <= 32'd0;
      swe_r    <= 1'b0;
    end else begin
      awready <= awvalid & ~awHeld_r & ~awready;
      wready  <= wvalid & ~wHeld_r & ~wready;
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awA_r    <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wD_r    <= wdata;
        wS_r    <= wstrb;
      end
      if (wrGo) begin
        bvalid   <= 1'b1;
        bresp    <= wrOk ? RESP_OK : RESP_ERR;
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        if (wrCtrl && wS_r[0]) swe_r <= wD_r[0] & pinS2_r[3];
      end
      if (bvalid && bready) bvalid <= 1'b0;
      arready <= arvalid & ~arready & ~rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdMux;
        rresp  <= rdOk ? RESP_OK : RESP_ERR;
      end
      if (rvalid && rready) rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_boot_entry: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    (initRise && isBoot && (initLong || !bootMode_r)) |=> bootMode_r)
    else $error("boot mode not entered at release");
  a_mode_track: assert property (@(posedge ref_clk) disable iff (!rst_b) // R18
    (!initS && initLong) |=> (opMode == $past(pinMode)) ##1 (expandedBus == ~$past(opMode[0])))
    else $error("operating mode does not follow pins");
  a_settle_wait: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
    (st_r == S_SETTLE && st_nxt == S_WLOW) |-> settleCnt_r == 7'(SETTLE_CYC - 1) && $past(st_r, 99) == S_SETTLE)
    else $error("low timing armed early");
  a_divisor_ninth: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
    (st_r == S_MEAS && rxS && bitCnt_r != 16'd0) |=> div_r == $past(bitCnt_r))
    else $error("divisor not ninth of low count");
  a_ack_single: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    txStart_r |=> !txStart_r [*8])
    else $error("more than one completion byte");
  a_load_window: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    ramWrEn |-> (ramWrAddr >= LOAD_LO && ramWrAddr <= LOAD_HI))
    else $error("program write outside load window");
  a_branch_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
    branchReq |-> (branchAddr == LOAD_LO && !txEn_r && !rxEn_r && div_r == $past(div_r)) ##2 bootSerialTxPin)
    else $error("serial unit not stopped at branch");
  a_erase_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
    branchReq |-> flashClean_r && !eraseAllReq)
    else $error("branch before flash erased");
  a_reserve_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
    (bootMode_r && !branched_r) |=> loaderReserved || branched_r)
    else $error("loader region released early");
  a_irq_block: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
    flashBusy |=> irqBlock)
    else $error("interrupts open during flash work");
  a_read_block: assert property (@(posedge ref_clk) disable iff (!rst_b) // R19
    (userProg && swe_r) |=> flashReadBlock)
    else $error("flash readable while unlocked");
endmodule
`default_nettype wire

// ==== host_model.sv ====
/*
  Host partner on the boot serial link.
  Assumes both lines are pulled high on the board.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int BIT_NS = 80
) (
  // Serial lines
  output logic      rxLine,
  input  wire logic txLine,
  input  wire logic txOe
);
  logic [7:0] lastRx;
  int         rxCount = 0;
  initial begin
    rxLine = 1'b1;
  end
  task automatic send(input logic [7:0] d);
    #1;
    rxLine = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rxLine = d[i];
      #(BIT_NS);
    end
    rxLine = 1'b1;
    #(BIT_NS);
  endtask
  task automatic handshake();
    for (int n = 0; n < 20 && rxCount == 0; n++) send(8'h00);
    if (lastRx === 8'h00) send(8'h55);
  endtask
  always begin
    @(negedge txLine);
    if (txOe === 1'b1) begin
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        lastRx[i] = txLine;
      end
      rxCount++;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking bench for the serial boot entry block.
  Assumes boot_pkg, the design and host_model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import boot_pkg::*;
;
  logic        ref_clk, rst_b, flashWriteEnablePin, modeSelectBit2, modeSelectBit1, modeSelectBit0;
  logic        hardwareInitPin_b, bootSerialRxPin, bootSerialTxPin, bootSerialTxPinOe, flashBlank;
  logic        eraseDone, flashBusy, eraseAllReq, irqBlock, flashReadBlock, loaderReserved, branchReq;
  logic        expandedBus, ramWrEn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  opMode, periphMode, awaddr, araddr, wstrb;
  logic [7:0]  ramWrData;
  logic [23:0] branchAddr, ramWrAddr, branchAt;
  logic        branchSeen = 1'b0;
  logic [31:0] wdata, rdata, v;
  logic [23:0] wrAddrQ[$];
  logic [7:0]  wrDataQ[$];
  int          errTotal, comparisons;
  boot_loader_entry i_boot_loader_entry (
    .ref_clk, .rst_b, .flashWriteEnablePin, .modeSelectBit2, .modeSelectBit1, .modeSelectBit0,
    .hardwareInitPin_b, .bootSerialRxPin, .bootSerialTxPin, .bootSerialTxPinOe, .flashBlank, .eraseDone,
    .flashBusy, .eraseAllReq, .irqBlock, .flashReadBlock, .loaderReserved, .branchReq, .branchAddr,
    .opMode, .periphMode, .expandedBus, .ramWrEn, .ramWrAddr, .ramWrData, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready
  );
  host_model i_host_model (.rxLine(bootSerialRxPin), .txLine(bootSerialTxPin), .txOe(bootSerialTxPinOe));
  // ****************
  // Helpers
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (ramWrEn === 1'b1) begin
    wrAddrQ.push_back(ramWrAddr);
    wrDataQ.push_back(ramWrData);
  end
  always @(posedge ref_clk) if (branchReq === 1'b1) begin
    branchSeen <= 1'b1;
    branchAt   <= branchAddr;
  end
  task automatic testDone();
    if (errTotal == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errTotal++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic waitHi(ref logic s, input int lim);
    int n;
    for (n = 0; n < lim && s !== 1'b1; n++) @(posedge ref_clk);
    if (n == lim) begin
      errTotal++;
      testDone();
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) begin
      errTotal++;
      testDone();
    end else begin
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task automatic axr(input logic [3:0] a);
    int n;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) begin
      errTotal++;
      testDone();
    end else begin
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic bootEntry();
    cyc(2);
    hardwareInitPin_b <= 1'b1;
    cyc(6);
    chk({opMode, expandedBus, loaderReserved, bootSerialTxPinOe}, {MODE_BOOT_SC, 3'b011});
  endtask
  task automatic bootDownload();
    cyc(SETTLE_CYC + 10);
    i_host_model.handshake();
    chk(i_host_model.lastRx, ACK_BYTE);
    waitHi(eraseAllReq, 500);
    cyc(2);
    chk(irqBlock, 1'b1);
    {flashBusy, eraseDone} <= 2'b11;
    cyc(1);
    eraseDone <= 1'b0;
    cyc(3);
    chk({irqBlock, eraseAllReq}, 2'b10);
    flashBusy <= 1'b0;
    i_host_model.send(8'h00);
    i_host_model.send(8'h02);
    i_host_model.send(8'ha5);
    i_host_model.send(8'h3c);
    waitHi(branchSeen, 400);
    chk(branchAt, LOAD_LO);
    chk(wrAddrQ.size(), 2);
    chk({wrAddrQ[1], wrDataQ[0]}, {LOAD_LO + 24'h1, 8'ha5});
    chk(wrDataQ[1], 8'h3c);
    cyc(3);
    chk({bootSerialTxPinOe, bootSerialTxPin, loaderReserved}, 3'b110);
    chk(i_host_model.rxCount, 1);
    axr(OFS_DIV);
    chk(v, 32'd20);
  endtask
  task automatic userProgram();
    hardwareInitPin_b <= 1'b0;
    {modeSelectBit2, modeSelectBit0} <= 2'b10;
    cyc(INIT_MIN_CYC + 8);
    hardwareInitPin_b <= 1'b1;
    cyc(6);
    chk({opMode, periphMode, expandedBus}, {MODE_UPG_EXP, MODE_USER_EXP, 1'b1});
    axw(OFS_CTRL, 32'h1);
    cyc(2);
    chk({resp, flashReadBlock}, {RESP_OK, 1'b1});
    axw(4'h2, 32'h0);
    chk(resp, RESP_ERR);
    axr(4'h2);
    chk(resp, RESP_ERR);
  endtask
  initial begin
    {rst_b, hardwareInitPin_b, modeSelectBit2, awvalid, wvalid, bready, arvalid, rready} = '0;
    {flashWriteEnablePin, modeSelectBit1, modeSelectBit0, eraseDone, flashBusy, flashBlank} = 6'b111000;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0, 4'hf};
    errTotal = 0;
    comparisons = 0;
    cyc(20);
    rst_b <= 1'b1;
    bootEntry();
    bootDownload();
    userProgram();
    testDone();
  end
endmodule
`default_nettype wire
